// ==== src/ncs_pkg.sv ====
// Constants and types for the oscillator select block.
// Assumes a single pclk domain and an APB register slave.
package ncs_pkg;
  localparam int NCS_NUM_OSC = 4;
  localparam int NCS_PHASE_W = 32;
  localparam int NCS_SYNC_STAGES = 2;
  localparam logic [11:0] NCS_OFF_CTRL = 12'h000;
  localparam logic [11:0] NCS_OFF_STAT = 12'h004;
  localparam logic [11:0] NCS_OFF_FREQ_A0 = 12'h010;
  localparam logic [11:0] NCS_OFF_FREQ_B0 = 12'h020;
  localparam int NCS_CTRL_PINMODE_BIT = 0;
  localparam int NCS_CTRL_CPLX_BIT = 1;
  localparam int NCS_STAT_SELA_LSB = 0;
  localparam int NCS_STAT_SELB_LSB = 4;
  localparam logic [1:0] NCS_CTRL_RESET = 2'h0;
  localparam logic [31:0] NCS_FREQ_RESET = 32'h0000_0000;
  typedef struct packed {
    logic msb;
    logic lsb;
  } ncs_sel_pins_t;
endpackage : ncs_pkg

// ==== src/ncs_osc_bank.sv ====
// Bank of four free-running phase accumulators for one down-converter.
// Assumes frequency words and a synchronised select index on pclk.
`timescale 1ns/100ps
module ncs_osc_bank
  import ncs_pkg::*;
#(
  parameter int PHASE_W = NCS_PHASE_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [NCS_NUM_OSC*PHASE_W-1:0] freq,
  input wire logic [1:0] sel,
  output logic [PHASE_W-1:0] phase
);
  logic [PHASE_W-1:0] acc_reg [NCS_NUM_OSC];
  genvar i;
  generate
    for (i = 0; i < NCS_NUM_OSC; i++) begin : g_acc
      // Every accumulator advances, selected or not
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          acc_reg[i] <= '0;
        end else begin
          acc_reg[i] <= acc_reg[i] + freq[i*PHASE_W +: PHASE_W];
        end
      end
    end
  endgenerate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= '0;
    end else begin
      phase <= acc_reg[sel];
    end
  end
endmodule : ncs_osc_bank

// ==== src/ncs_osc_select.sv ====
// Functional notes
// - DDC A mixes with one of four oscillators chosen by its pins.
// - DDC B mixes with one of four oscillators chosen by its pins.
// - A pins form an index: lsb pin bit 0, msb pin bit 1.
// - B pins form an index the same way, msb pin is bit 1.
// - Unselected oscillators keep advancing phase for coherent swaps.
// - Pin changes swap the oscillator only while pin-control mode is 1.
// - Select pins are asynchronous to every device clock.
//
// Top of the pin-driven oscillator select, with an APB register slave.
// Assumes select pins are asynchronous; APB runs on pclk.
//
// The address map and register access over APB are this design's own decisions.
`timescale 1ns/100ps
module ncs_osc_select
  import ncs_pkg::*;
#(
  parameter int PHASE_W = NCS_PHASE_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic osc_sel_a_lsb,
  input wire logic osc_sel_a_msb,
  input wire logic osc_sel_b_lsb,
  input wire logic osc_sel_b_msb,
  output logic [PHASE_W-1:0] mix_phase_a,
  output logic [PHASE_W-1:0] mix_phase_b
);
  // Synchroniser chains, pins packed as index bits
  ncs_sel_pins_t pins_a;
  ncs_sel_pins_t pins_b;
  assign pins_a = '{msb: osc_sel_a_msb, lsb: osc_sel_a_lsb};
  assign pins_b = '{msb: osc_sel_b_msb, lsb: osc_sel_b_lsb};
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  // Two stages, pins treated as fully asynchronous
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 4'h0;
    end else begin
      sync1_reg <= {pins_b, pins_a};
    end
  end
  // Only the second stage feeds the select logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync2_reg <= 4'h0;
    end else begin
      sync2_reg <= sync1_reg;
    end
  end
  // Converter A in bits 1:0, converter B in bits 3:2
  wire [1:0] pin_idx_a = sync2_reg[1:0];
  wire [1:0] pin_idx_b = sync2_reg[3:2];
  // Registers
  logic [1:0] ctrl_reg;
  logic [PHASE_W-1:0] freq_a_reg [NCS_NUM_OSC];
  logic [PHASE_W-1:0] freq_b_reg [NCS_NUM_OSC];
  logic [1:0] sel_a_reg;
  logic [1:0] sel_b_reg;
  wire pin_mode = ctrl_reg[NCS_CTRL_PINMODE_BIT];
  wire cplx_mode = ctrl_reg[NCS_CTRL_CPLX_BIT];
  // Selection follows pins only in pin-control mode
  wire [1:0] sel_a_next = pin_mode ? pin_idx_a : sel_a_reg;
  wire [1:0] sel_b_next = pin_mode ? pin_idx_b : sel_b_reg;
  // With pin control off the last choice is held
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_a_reg <= 2'h0;
    end else begin
      sel_a_reg <= sel_a_next;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_b_reg <= 2'h0;
    end else begin
      sel_b_reg <= sel_b_next;
    end
  end
  // APB decode
  wire acc = psel && penable;
  // First access cycle launches the answer, the next completes it
  wire acc_first = acc && !pready;
  wire acc_done = acc && pready;
  wire wr = acc_done && pwrite;
  wire hit_ctrl = paddr == NCS_OFF_CTRL;
  wire hit_stat = paddr == NCS_OFF_STAT;
  wire [11:0] off_a = paddr - NCS_OFF_FREQ_A0;
  wire [11:0] off_b = paddr - NCS_OFF_FREQ_B0;
  wire hit_a = paddr[1:0] == 2'h0 && paddr >= NCS_OFF_FREQ_A0
    && off_a < 12'h010;
  wire hit_b = paddr[1:0] == 2'h0 && paddr >= NCS_OFF_FREQ_B0
    && off_b < 12'h010;
  wire [1:0] idx_a = off_a[3:2];
  wire [1:0] idx_b = off_b[3:2];
  wire mapped = hit_ctrl || hit_stat || hit_a || hit_b;
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_ctrl) begin
      rd_mux[1:0] = ctrl_reg;
    end else if (hit_stat) begin
      rd_mux[NCS_STAT_SELA_LSB +: 2] = sel_a_reg;
      rd_mux[NCS_STAT_SELB_LSB +: 2] = sel_b_reg;
    end else if (hit_a) begin
      rd_mux[PHASE_W-1:0] = freq_a_reg[idx_a];
    end else if (hit_b) begin
      rd_mux[PHASE_W-1:0] = freq_b_reg[idx_b];
    end
  end
  // Writes land at the completing edge; status and unmapped are dropped
  wire ctrl_we = wr && hit_ctrl;
  wire freq_a_we = wr && hit_a;
  wire freq_b_we = wr && hit_b;
  wire [1:0] ctrl_next = ctrl_we ? pwdata[1:0] : ctrl_reg;
  // Control: bit 0 pin-control mode, bit 1 complex output mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= NCS_CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int k = 0; k < NCS_NUM_OSC; k++) begin
        freq_a_reg[k] <= PHASE_W'(NCS_FREQ_RESET);
      end
    end else if (freq_a_we) begin
      freq_a_reg[idx_a] <= pwdata[PHASE_W-1:0];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int k = 0; k < NCS_NUM_OSC; k++) begin
        freq_b_reg[k] <= PHASE_W'(NCS_FREQ_RESET);
      end
    end else if (freq_b_we) begin
      freq_b_reg[idx_b] <= pwdata[PHASE_W-1:0];
    end
  end
  // One wait state: pready rises after the first access cycle
  wire pready_next = acc_first;
  // Unmapped accesses answer with pslverr and zero data
  wire pslverr_next = acc_first && !mapped;
  // Read data is launched in the first access cycle
  wire [31:0] prdata_next = acc_first ? rd_mux : 32'h0000_0000;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= pready_next;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= pslverr_next;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= prdata_next;
    end
  end
  // Frequency words flattened for the banks
  logic [NCS_NUM_OSC*PHASE_W-1:0] freq_a_flat;
  logic [NCS_NUM_OSC*PHASE_W-1:0] freq_b_flat;
  genvar g;
  generate
    for (g = 0; g < NCS_NUM_OSC; g++) begin : g_flat
      assign freq_a_flat[g*PHASE_W +: PHASE_W] = freq_a_reg[g];
      assign freq_b_flat[g*PHASE_W +: PHASE_W] = freq_b_reg[g];
    end
  endgenerate
  logic [PHASE_W-1:0] phase_a;
  logic [PHASE_W-1:0] phase_b;
  // Per-DDC oscillator choice
  ncs_osc_bank #(.PHASE_W(PHASE_W)) u_bank_a (
    .pclk(pclk),
    .presetn(presetn),
    .freq(freq_a_flat),
    .sel(sel_a_reg),
    .phase(phase_a)
  );
  ncs_osc_bank #(.PHASE_W(PHASE_W)) u_bank_b (
    .pclk(pclk),
    .presetn(presetn),
    .freq(freq_b_flat),
    .sel(sel_b_reg),
    .phase(phase_b)
  );
  // Mixing phase only in complex output mode
  wire [PHASE_W-1:0] mix_phase_a_next = cplx_mode ? phase_a : '0;
  wire [PHASE_W-1:0] mix_phase_b_next = cplx_mode ? phase_b : '0;
  // Real output modes carry no mixing phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mix_phase_a <= '0;
    end else begin
      mix_phase_a <= mix_phase_a_next;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mix_phase_b <= '0;
    end else begin
      mix_phase_b <= mix_phase_b_next;
    end
  end
endmodule : ncs_osc_select

// ==== testbench/ncs_osc_select_properties.sv ====
// Port checks for the oscillator select top.
// Assumes one pclk domain and an active-low reset.
`timescale 1ns/100ps
module ncs_osc_select_properties
  import ncs_pkg::*;
#(
  parameter int PHASE_W = NCS_PHASE_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [PHASE_W-1:0] mix_phase_a,
  input wire logic [PHASE_W-1:0] mix_phase_b
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Complex mode bit as last written over the bus
  logic cplx_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cplx_q <= 1'b0;
    end else if (psel && penable && pready && pwrite
      && paddr == NCS_OFF_CTRL) begin
      cplx_q <= pwdata[NCS_CTRL_CPLX_BIT];
    end
  end
  a_real_zero: assert property (!cplx_q && !$past(cplx_q)
    |-> mix_phase_a == '0 && mix_phase_b == '0)
    else $error("mixing phase in real mode");
  a_rdy_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_rdy_wait: assert property ($rose(penable) && psel |=> pready)
    else $error("no answer after one wait state");
  a_rdy_cause: assert property (pready |-> $past(psel && penable))
    else $error("pready without access");
  a_err_pair: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_err_zero: assert property (pslverr |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_rd_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  a_no_access: assert property (!psel |=> !pready)
    else $error("pready while idle");
  a_reset_quiet: assert property ($rose(presetn) |-> mix_phase_a == 0)
    else $error("phase not clear after reset");
  c_err: cover property (pslverr);
  c_read: cover property (pready && !pslverr);
  c_mix: cover property (mix_phase_a != 0);
  c_mix_b: cover property (mix_phase_b != 0);
endmodule : ncs_osc_select_properties
bind ncs_osc_select ncs_osc_select_properties #(.PHASE_W(PHASE_W))
  ncs_osc_select_properties_inst (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .mix_phase_a(mix_phase_a),
  .mix_phase_b(mix_phase_b));

// ==== testbench/ncs_pin_ctrl.sv ====
// Outside controller driving both select pin pairs.
// Assumes the bench gives the wanted index per converter.
`timescale 1ns/100ps
module ncs_pin_ctrl
  import ncs_pkg::*;
(
  input wire logic [1:0] idx_a,
  input wire logic [1:0] idx_b,
  output ncs_sel_pins_t pins_a,
  output ncs_sel_pins_t pins_b
);
  // Skewed off the clock: pins are asynchronous
  assign #1.3 pins_a = ncs_sel_pins_t'(idx_a);
  assign #2.1 pins_b = ncs_sel_pins_t'(idx_b);
endmodule : ncs_pin_ctrl

// ==== testbench/tb_top.sv ====
// Bench for the oscillator select top over APB.
// Assumes ncs_pkg and the pin controller model.
`timescale 1ns/100ps
`define CHK(n, e, a) checked++; if ((a) !== (e)) begin failures++; \
  $display("unexpected %s exp %h got %h", n, e, a); end
module tb_top
  import ncs_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rdat, p, q;
  logic pready, pslverr, rerr;
  logic [1:0] sa = 2'h0, sb = 2'h0;
  logic [31:0] mix_phase_a, mix_phase_b;
  ncs_sel_pins_t pa, pb;
  int failures = 0, checked = 0;
  always #2.5 pclk = ~pclk;
  ncs_pin_ctrl ncs_pin_ctrl_inst (.idx_a(sa), .idx_b(sb), .pins_a(pa),
    .pins_b(pb));
  ncs_osc_select ncs_osc_select_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .osc_sel_a_lsb(pa.lsb), .osc_sel_a_msb(pa.msb), .osc_sel_b_lsb(pb.lsb),
    .osc_sel_b_msb(pb.msb), .mix_phase_a(mix_phase_a),
    .mix_phase_b(mix_phase_b));
  task automatic print_verdict;
    if (failures == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) failures++;
    rdat = prdata; rerr = pslverr; psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  function automatic logic [31:0] fq(int k);
    return 32'h1000_0000 >> k;
  endfunction : fq
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, NCS_OFF_CTRL, 0); `CHK("ctrl", 32'(NCS_CTRL_RESET), rdat)
    apb(0, 12'hff0, 0); `CHK("unmapped", 1'b1, rerr)
    `CHK("unmapped_rd", 32'h0, rdat)
    for (int k = 0; k < 4; k++) begin
      apb(1, NCS_OFF_FREQ_A0 + 12'(4 * k), fq(k));
      apb(1, NCS_OFF_FREQ_B0 + 12'(4 * k), fq(k) + 32'h5);
    end
    apb(0, NCS_OFF_FREQ_B0 + 12'h00c, 0);
    `CHK("freq_b3", fq(3) + 32'h5, rdat)
    apb(1, NCS_OFF_CTRL, 32'h3);
    for (int k = 0; k < 4; k++) begin
      sa <= 2'(k); sb <= 2'(3 - k);
      repeat (10) @(posedge pclk);
      apb(0, NCS_OFF_STAT, 0);
      `CHK("stat", 32'(k) | 32'(3 - k) << NCS_STAT_SELB_LSB, rdat)
      @(posedge pclk); p = mix_phase_a; q = mix_phase_b;
      @(posedge pclk);
      `CHK("step_a", fq(k), mix_phase_a - p)
      `CHK("step_b", fq(3 - k) + 32'h5, mix_phase_b - q)
    end
    @(posedge pclk); p = mix_phase_a;
    sa <= 2'h0;
    repeat (20) @(posedge pclk);
    sa <= 2'h3;
    repeat (20) @(posedge pclk);
    `CHK("coherent", 32'(40) * fq(3), mix_phase_a - p)
    apb(1, NCS_OFF_CTRL, 32'h2);
    sa <= 2'h1; sb <= 2'h2;
    repeat (10) @(posedge pclk);
    apb(0, NCS_OFF_STAT, 0); `CHK("held", 32'h3, rdat)
    apb(1, NCS_OFF_CTRL, 32'h1);
    repeat (6) @(posedge pclk);
    `CHK("real_mode", 32'h0, mix_phase_a)
    `CHK("real_mode_b", 32'h0, mix_phase_b)
    apb(0, NCS_OFF_STAT, 0);
    `CHK("follow", 32'h1 | 32'h2 << NCS_STAT_SELB_LSB, rdat)
    print_verdict();
  end
endmodule : tb_top
